// >>> rtl/mci_pkg.sv
// package: register map, field positions, reset values and frame counts
// for the master control and status register group.
// assumes a 32-bit AXI4-Lite bus with one 8-bit register per aligned word.
package mci_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [2:0] IDX_CTRL   = 3'h1;
  localparam logic [2:0] IDX_STAT   = 3'h2;
  localparam logic [2:0] IDX_RSTID  = 3'h3;
  localparam logic [2:0] IDX_TXCTRL = 3'h4;

  // ==========================================================================
  // master control/enable bits
  localparam int BIT_RX_LINE_EN   = 0;
  localparam int BIT_MUX_EN       = 1;
  localparam int BIT_RX_SEC_EN    = 2;
  localparam int BIT_SER_EN       = 3;
  localparam int BIT_APS_EN       = 4;
  localparam int BIT_PSBF_EN      = 5;
  localparam int BIT_GROWTH_EN    = 6;
  localparam int BIT_RING_PORT_EN = 7;

  // master interrupt status bits
  localparam int BIT_APS_ST    = 4;
  localparam int BIT_PSBF_EV   = 5;
  localparam int BIT_GROWTH_ST = 6;

  // reset and identity bits
  localparam int BIT_SW_RESET = 7;

  // transmit line overhead control bits
  localparam int BIT_FAR_END_FAIL = 0;
  localparam int BIT_ORDERWIRE    = 1;
  localparam int BIT_LINE_DCC     = 2;
  localparam int BIT_UNUSED_PASS  = 6;

  // ==========================================================================
  // reset values and codes
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [6:0] TXCTRL_RST = 7'h00;
  localparam logic [2:0] FAR_END_FAIL_INSERT_CODE  = 3'h6;

  // frame counts of the receive byte monitors
  localparam logic [1:0] APS_PERSIST_FRAMES = 2'h3;
  localparam logic [1:0] K1_STABLE_FRAMES   = 2'h3;
  localparam logic [3:0] PSBF_FAIL_FRAMES   = 4'hc;

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // transmit byte position as marked by the upstream frame counter
  typedef enum logic [2:0] {
    POS_OTHER      = 3'b000,
    POS_K2         = 3'b001,
    POS_E2         = 3'b010,
    POS_E2_UNUSED  = 3'b011,
    POS_DCC        = 3'b100,
    POS_DCC_UNUSED = 3'b101
  } mci_txpos_t;

  // ==========================================================================
  function automatic logic [2:0] mciIdx(input logic [31:0] addr);
    mciIdx = addr[4:2];
  endfunction : mciIdx

  function automatic logic mciMapped(input logic [31:0] addr);
    logic [2:0] i;
    i = addr[4:2];
    mciMapped = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0) &&
                (i >= IDX_CTRL) && (i <= IDX_TXCTRL);
  endfunction : mciMapped

endpackage : mci_pkg

// >>> rtl/mci_reg_if.sv
// interface: register strobes between the bus front end and the core.
// assumes one clock shared by both ends.
`timescale 1ns/1ns
interface mci_reg_if;
  logic       wrEn;
  logic [2:0] wrIdx;
  logic [7:0] wdata;
  logic       rdEn;
  logic [2:0] rdIdx;
  logic [7:0] rdata;
  logic       swReset;

  modport front (output wrEn, wrIdx, wdata, rdEn, rdIdx, swReset,
                 input rdata);
  modport core  (input wrEn, wrIdx, wdata, rdEn, rdIdx, swReset,
                 output rdata);
endinterface : mci_reg_if

// >>> rtl/mci_axil_slave.sv
// AXI4-Lite slave front end; turns bus transfers into one-cycle strobes.
// assumes the core answers rdata combinationally from rdIdx.
// reset only by the pin so software can always release the soft reset.
`timescale 1ns/1ns
module mci_axil_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core side
  mci_reg_if.front         bus
);
  import mci_pkg::*;

  typedef struct packed {
    logic       awHeld;
    logic [2:0] awIdx;
    logic       awOk;
    logic       wHeld;
    logic [7:0] wData;
    logic       wLane;
    logic       bValid;
    logic [1:0] bResp;
    logic       rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic       swReset;
  } mci_fe_t;

  mci_fe_t st_q;
  mci_fe_t st_d;
  logic    doWrite;
  logic    arTake;

  // ==========================================================================
  // handshakes
  assign s_axi_awready = !st_q.awHeld && !st_q.bValid;
  assign s_axi_wready  = !st_q.wHeld && !st_q.bValid;
  assign s_axi_arready = !st_q.rValid;
  assign doWrite       = st_q.awHeld && st_q.wHeld && !st_q.bValid;
  assign arTake        = s_axi_arvalid && s_axi_arready;

  assign bus.wrEn    = doWrite && st_q.awOk && st_q.wLane;
  assign bus.wrIdx   = st_q.awIdx;
  assign bus.wdata   = st_q.wData;
  assign bus.rdEn    = arTake && mciMapped(s_axi_araddr);
  assign bus.rdIdx   = mciIdx(s_axi_araddr);
  assign bus.swReset = st_q.swReset;

  assign s_axi_bvalid = st_q.bValid;
  assign s_axi_bresp  = st_q.bResp;
  assign s_axi_rvalid = st_q.rValid;
  assign s_axi_rresp  = st_q.rResp;
  assign s_axi_rdata  = {24'h0, st_q.rData};

  // ==========================================================================
  always_comb begin
    st_d = st_q;
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.awHeld = 1'b1;
      st_d.awIdx  = mciIdx(s_axi_awaddr);
      st_d.awOk   = mciMapped(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.wHeld = 1'b1;
      st_d.wData = s_axi_wdata[7:0];
      st_d.wLane = s_axi_wstrb[0];
    end
    if (doWrite) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = st_q.awOk ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.bValid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end
    if (bus.wrEn && (st_q.awIdx == IDX_RSTID)) begin
      st_d.swReset = st_q.wData[BIT_SW_RESET];
    end
    if (arTake) begin
      st_d.rValid = 1'b1;
      st_d.rData  = bus.rdEn ? bus.rdata : 8'h00;
      st_d.rResp  = bus.rdEn ? RESP_OKAY : RESP_SLVERR;
    end else if (st_q.rValid && s_axi_rready) begin
      st_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : mci_axil_slave

// >>> rtl/mci_aps_mon.sv
// receive K1/K2 and Z1 byte monitor, one update per frame strobe.
// assumes the bytes are valid in the cycle that frameStb is high.
`timescale 1ns/1ns
module mci_aps_mon (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // extracted bytes
  input  wire logic       frameStb,
  input  wire logic [7:0] k1In,
  input  wire logic [7:0] k2In,
  input  wire logic [7:0] z1In,
  // captured values and events
  output      logic [7:0] rxK1,
  output      logic [7:0] rxK2,
  output      logic [7:0] rxZ1,
  output      logic       apsChangeEv,
  output      logic       growthChangeEv,
  output      logic       psbfState,
  output      logic       psbfChangeEv
);
  import mci_pkg::*;

  typedef struct packed {
    logic [7:0] candK1;
    logic [7:0] candK2;
    logic [1:0] candRun;
    logic [7:0] rxK1;
    logic [7:0] rxK2;
    logic [7:0] rxZ1;
    logic [7:0] lastK1;
    logic [1:0] k1Run;
    logic [3:0] badCnt;
    logic       psbf;
    logic       apsEv;
    logic       zEv;
    logic       psbfEv;
  } mci_mon_t;

  mci_mon_t st_q;
  mci_mon_t st_d;

  assign rxK1           = st_q.rxK1;
  assign rxK2           = st_q.rxK2;
  assign rxZ1           = st_q.rxZ1;
  assign apsChangeEv    = st_q.apsEv;
  assign growthChangeEv = st_q.zEv;
  assign psbfState      = st_q.psbf;
  assign psbfChangeEv   = st_q.psbfEv;

  // ==========================================================================
  always_comb begin
    st_d        = st_q;
    st_d.apsEv  = 1'b0;
    st_d.zEv    = 1'b0;
    st_d.psbfEv = 1'b0;
    if (frameStb) begin
      if ((k1In == st_q.candK1) && (k2In == st_q.candK2)) begin
        if (st_q.candRun != APS_PERSIST_FRAMES) begin
          st_d.candRun = st_q.candRun + 2'h1;
        end
      end else begin
        st_d.candK1  = k1In;
        st_d.candK2  = k2In;
        st_d.candRun = 2'h1;
      end
      if ((st_d.candRun == APS_PERSIST_FRAMES) &&
          ({st_d.candK1, st_d.candK2} != {st_q.rxK1, st_q.rxK2})) begin
        st_d.rxK1  = st_d.candK1;
        st_d.rxK2  = st_d.candK2;
        st_d.apsEv = 1'b1;
      end
      if (z1In != st_q.rxZ1) begin
        st_d.rxZ1 = z1In;
        st_d.zEv  = 1'b1;
      end
      st_d.lastK1 = k1In;
      if (k1In == st_q.lastK1) begin
        if (st_q.k1Run != K1_STABLE_FRAMES) begin
          st_d.k1Run = st_q.k1Run + 2'h1;
        end
      end else begin
        st_d.k1Run = 2'h1;
      end
      if (st_d.k1Run == K1_STABLE_FRAMES) begin
        st_d.badCnt = 4'h0;
        st_d.psbf   = 1'b0;
      end else if (st_q.badCnt != PSBF_FAIL_FRAMES) begin
        st_d.badCnt = st_q.badCnt + 4'h1;
        if (st_d.badCnt == PSBF_FAIL_FRAMES) begin
          st_d.psbf = 1'b1;
        end
      end
      st_d.psbfEv = st_d.psbf != st_q.psbf;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : mci_aps_mon

// >>> rtl/mci_master_ctrl.sv
// top: master control, interrupt status, reset/identity and transmit line
// overhead control registers, with activity monitors and byte insertion.
// assumes all pins are synchronous to clk; clock pins are sampled levels.
`timescale 1ns/1ns

// Operation
// - mux and serializer alignment errors interrupt only when enabled
// - receive section events interrupt only when enabled
// - new captured K1/K2 value interrupts when enabled
// - every protection byte failure change interrupts when enabled
// - Z1 change interrupts when enabled
// - ring port enable picks ring word or discrete alarm pins
// - receive line summary sticks until its sub-block status read
// - mux and serializer summaries stick until sub-block read
// - receive section summary sticks until its status read
// - K1/K2 captured after three identical frames; flag clears on read
// - failure change flag sets on change, clears on status read
// - Z1 register loads on change; flag clears on status read
// - failure after twelve bad frames, cleared by three stable K1
// - a write to reset/identity register snaps performance counters if soft reset stays clear
// - three-bit version field in the low bits
// - receive bus activity since last read
// - per-clock activity since last read
// - software reset bit resets device until written zero
// - far-end fail forces K2 low bits to 110
// - orderwire pass or serial source for E2, unused bytes zeroed
// - line DCC pass or serial source, unused bytes zeroed
module mci_master_ctrl #(
  // arbitrary value, not tied to any part
  parameter logic [2:0] VERSION = 3'h5
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // axi4-lite
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // sub-block events (pulses) and acknowledging reads (pulses)
  input  wire logic                rxLineEvent,
  input  wire logic                rxLineAck,
  input  wire logic                muxAlignErr,
  input  wire logic                muxAlignAck,
  input  wire logic                rxSectionEvent,
  input  wire logic                rxSectionAck,
  input  wire logic                serializerAlignErr,
  input  wire logic                serializerAlignAck,
  // receive frame bytes
  input  wire logic                rxFrameStb,
  input  wire logic [7:0]          rxK1In,
  input  wire logic [7:0]          rxK2In,
  input  wire logic [7:0]          rxZ1In,
  // activity monitor inputs
  input  wire logic [7:0]          rxByteIn,
  input  wire logic                rxFramePosition,
  input  wire logic                lowSpeedTxClock,
  input  wire logic                txClock,
  input  wire logic                rxClock,
  // alarm sources and maintenance requests
  input  wire logic                sigLossAlarm,
  input  wire logic                lineAisAlarm,
  input  wire logic                lineFerfAlarm,
  input  wire logic                rxAisForceIn,
  input  wire logic                txAisForceIn,
  input  wire logic                txFarEndFailIn,
  input  wire logic [2:0]          txRingData,
  // transmit byte stream
  input  wire logic [7:0]          txInLane1,
  input  wire mci_pkg::mci_txpos_t txPos,
  input  wire logic                txInsertBypass,
  input  wire logic                txOverheadInsertEn,
  input  wire logic [7:0]          orderwireSerialIn,
  input  wire logic [7:0]          lineDccSerialIn,
  // outputs
  output      logic [7:0]          txByteOut,
  output      logic                signalLossOut,
  output      logic                lineAisOut,
  output      logic                lineFerfOut,
  output      logic [2:0]          rxRingData,
  output      logic                rxAisForce,
  output      logic                txAisForce,
  output      logic                pmSnapshot,
  output      logic [7:0]          rxK1,
  output      logic [7:0]          rxK2,
  output      logic [7:0]          rxZ1,
  output      logic                coreReset,
  output      logic                irq
);
  import mci_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [6:0] txCtrl;
    logic [6:0] stat;
    logic [3:0] act;
    logic [7:0] prevRin;
    logic       prevFp;
    logic [2:0] prevClk;
    logic [7:0] txOut;
    logic       snap;
    logic [2:0] discOut;
    logic [2:0] ringOut;
    logic [1:0] aisForce;
    logic       irq;
  } mci_core_t;

  mci_core_t  st_q;
  mci_core_t  st_d;
  mci_reg_if  bus ();
  logic       coreRst;
  logic       apsEv;
  logic       growthEv;
  logic       psbfState;
  logic       psbfEv;
  logic [6:0] statSet;
  logic [6:0] statClr;
  logic [3:0] actSet;
  logic [2:0] maint;
  logic       ferfForce;
  logic       statRead;
  logic       rstIdRead;

  // ==========================================================================
  // bus front end and frame monitor
  mci_axil_slave u_front (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .bus           (bus.front)
  );

  // soft reset joins pin reset
  // the bit is a flop output, so the combined reset is glitch free; the
  // front end is outside it so software can still write the bit to zero
  assign coreRst   = sys_rst | bus.swReset;
  assign coreReset = coreRst;

  mci_aps_mon u_mon (
    .clk            (clk),
    .rst            (coreRst),
    .frameStb       (rxFrameStb),
    .k1In           (rxK1In),
    .k2In           (rxK2In),
    .z1In           (rxZ1In),
    .rxK1           (rxK1),
    .rxK2           (rxK2),
    .rxZ1           (rxZ1),
    .apsChangeEv    (apsEv),
    .growthChangeEv (growthEv),
    .psbfState      (psbfState),
    .psbfChangeEv   (psbfEv)
  );

  // ==========================================================================
  // read data and read side effects
  assign statRead  = bus.rdEn && (bus.rdIdx == IDX_STAT);
  assign rstIdRead = bus.rdEn && (bus.rdIdx == IDX_RSTID);

  always_comb begin
    case (bus.rdIdx)
      IDX_CTRL:   bus.rdata = st_q.ctrl;
      IDX_STAT:   bus.rdata = {psbfState, st_q.stat};
      IDX_RSTID:  bus.rdata = {bus.swReset, st_q.act, VERSION};
      IDX_TXCTRL: bus.rdata = {1'b0, st_q.txCtrl};
      default:    bus.rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // status set and clear terms
  always_comb begin
    statSet[0] = rxLineEvent;
    statClr[0] = rxLineAck;
    statSet[1] = muxAlignErr;
    statClr[1] = muxAlignAck;
    statSet[2] = rxSectionEvent;
    statClr[2] = rxSectionAck;
    statSet[3] = serializerAlignErr;
    statClr[3] = serializerAlignAck;
    statSet[BIT_APS_ST] = apsEv;
    statClr[BIT_APS_ST] = statRead;
    statSet[BIT_PSBF_EV] = psbfEv;
    statClr[BIT_PSBF_EV] = statRead;
    statSet[BIT_GROWTH_ST] = growthEv;
    statClr[BIT_GROWTH_ST] = statRead;
  end

  assign actSet[0] = (rxByteIn != st_q.prevRin) ||
                     (rxFramePosition != st_q.prevFp);
  assign actSet[3:1] = {rxClock, txClock, lowSpeedTxClock} ^ st_q.prevClk;

  // ==========================================================================
  // ring or discrete maintenance requests
  // request source select
  assign maint = st_q.ctrl[BIT_RING_PORT_EN] ? txRingData
               : {txFarEndFailIn, txAisForceIn, rxAisForceIn};
  assign ferfForce = st_q.txCtrl[BIT_FAR_END_FAIL] | maint[2];

  // ==========================================================================
  always_comb begin
    st_d      = st_q;
    st_d.snap = 1'b0;

    if (bus.wrEn) begin
      case (bus.wrIdx)
        IDX_CTRL:   st_d.ctrl = bus.wdata;
        IDX_TXCTRL: st_d.txCtrl = bus.wdata[6:0];
        IDX_RSTID:  st_d.snap = 1'b1;
        default:    st_d.snap = 1'b0;
      endcase
    end

    // set wins over a clear in the same cycle
    st_d.stat = (st_q.stat & ~statClr) | statSet;
    st_d.act  = (st_q.act & ~{4{rstIdRead}}) | actSet;
    st_d.prevRin = rxByteIn;
    st_d.prevFp  = rxFramePosition;
    st_d.prevClk = {rxClock, txClock, lowSpeedTxClock};

    if (st_q.ctrl[BIT_RING_PORT_EN]) begin
      st_d.discOut = 3'h0;
      st_d.ringOut = {lineFerfAlarm, lineAisAlarm, sigLossAlarm};
    end else begin
      st_d.discOut = {lineFerfAlarm, lineAisAlarm, sigLossAlarm};
      st_d.ringOut = 3'h0;
    end
    st_d.aisForce = maint[1:0];

    // transmit overhead insertion
    if (txInsertBypass || txOverheadInsertEn) begin
      st_d.txOut = txInLane1;
    end else begin
      case (txPos)
        POS_K2: st_d.txOut = ferfForce ? {txInLane1[7:3], FAR_END_FAIL_INSERT_CODE}
                                       : txInLane1;
        POS_E2: st_d.txOut = st_q.txCtrl[BIT_ORDERWIRE] ? txInLane1
                                                        : orderwireSerialIn;
        POS_DCC: st_d.txOut = st_q.txCtrl[BIT_LINE_DCC] ? txInLane1
                                                        : lineDccSerialIn;
        POS_E2_UNUSED,
        POS_DCC_UNUSED: st_d.txOut = st_q.txCtrl[BIT_UNUSED_PASS] ? txInLane1
                                                                 : 8'h00;
        default: st_d.txOut = txInLane1;
      endcase
    end

    st_d.irq = |(st_d.stat & st_q.ctrl[6:0]);
  end

  always_ff @(posedge clk or posedge coreRst) begin
    if (coreRst) begin
      st_q        <= '0;
      st_q.ctrl   <= CTRL_RST;
      st_q.txCtrl <= TXCTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  assign txByteOut     = st_q.txOut;
  assign signalLossOut = st_q.discOut[0];
  assign lineAisOut    = st_q.discOut[1];
  assign lineFerfOut   = st_q.discOut[2];
  assign rxRingData    = st_q.ringOut;
  assign rxAisForce    = st_q.aisForce[0];
  assign txAisForce    = st_q.aisForce[1];
  assign pmSnapshot    = st_q.snap;
  assign irq           = st_q.irq;

endmodule : mci_master_ctrl

// >>> tb/mci_ctl_assertions.sv
// checker: bus answers, transmit insertion, alarm and reset relations.
// assumes it is bound onto mci_master_ctrl, one clock domain.
`timescale 1ns/1ns
module mci_ctl_assertions
  import mci_pkg::*;
(
  input wire logic       clk, sys_rst, irq, coreReset, pmSnapshot,
  input wire logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic       s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic       s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic       txInsertBypass, txOverheadInsertEn, txFarEndFailIn,
  input wire logic       signalLossOut, lineAisOut, lineFerfOut,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [2:0] txRingData, rxRingData,
  input wire logic [7:0] txInLane1, txByteOut,
  input wire mci_txpos_t txPos
);
  // ===============================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_far_end_fail_insert_code: assert property (txPos == POS_K2 && txFarEndFailIn
    && txRingData[2] && !txInsertBypass && !txOverheadInsertEn
    |=> txByteOut[2:0] == FAR_END_FAIL_INSERT_CODE) else $error("far_end_fail_insert code missing");
  chk_lane_pass: assert property (txInsertBypass || txPos == POS_OTHER
    || txOverheadInsertEn |=> txByteOut == $past(txInLane1))
    else $error("lane byte altered");
  chk_ring_excl: assert property (|rxRingData
    |-> !(signalLossOut || lineAisOut || lineFerfOut))
    else $error("both alarm paths active");
  chk_snap_pulse: assert property (pmSnapshot |=> !pmSnapshot)
    else $error("snapshot pulse too long");
  chk_soft_quiet: assert property (coreReset |=> !irq)
    else $error("irq during soft reset");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  cover property (pmSnapshot);
  cover property (irq);
  cover property (|rxRingData);
endmodule : mci_ctl_assertions

bind mci_master_ctrl mci_ctl_assertions mci_ctl_assertions_inst (.*);

// >>> tb/tb.sv
// bench: register tests of the master control block over the bus.
// assumes the package and the bound checker are compiled first.
`timescale 1ns/1ns
module tb;
  import mci_pkg::*;
  logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pmSnapshot, coreReset, irq, rxFrameStb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] rxRingData, alm = 0;
  logic [3:0] ev = 0, ack = 0, act = 0;
  logic [7:0] k1 = 0, z1 = 0, lane = 0, txByteOut, rxK1, rxZ1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_rdata, got;
  mci_txpos_t txPos = POS_OTHER;
  int errorCnt = 0, checks = 0, i, snapCnt = 0;
  always #2 clk = ~clk;
  // the snapshot stands one cycle only, so it is counted as it happens
  always @(posedge clk) if (pmSnapshot) snapCnt++;
  mci_master_ctrl mci_master_ctrl_inst (.*, .s_axi_wstrb(4'hf),
    .rxLineEvent(ev[0]), .muxAlignErr(ev[1]), .rxSectionEvent(ev[2]),
    .serializerAlignErr(ev[3]), .rxLineAck(ack[0]), .muxAlignAck(ack[1]),
    .rxSectionAck(ack[2]), .serializerAlignAck(ack[3]), .rxK1In(k1),
    .rxK2In(8'h22), .rxZ1In(z1), .rxByteIn(lane), .rxFramePosition(act[0]),
    .lowSpeedTxClock(act[1]), .txClock(act[2]), .rxClock(act[3]),
    .sigLossAlarm(alm[0]), .lineAisAlarm(alm[1]), .lineFerfAlarm(alm[2]),
    .rxAisForceIn(alm[0]), .txAisForceIn(alm[1]), .txFarEndFailIn(alm[2]),
    .txRingData({alm[2], 2'h0}), .txInLane1(lane), .txInsertBypass(alm[1]),
    .txOverheadInsertEn(1'b0), .orderwireSerialIn(8'h3c), .rxK2(),
    .lineDccSerialIn(8'hc3), .signalLossOut(), .lineAisOut(),
    .lineFerfOut(), .rxAisForce(), .txAisForce());
  // ===============================================================
  // tasks
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errorCnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic endSim;
    $display("errors %0d checks %0d", errorCnt, checks);
    if (errorCnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : endSim
  // one bus transfer; holds each valid until its ready is sampled
  task automatic acc(input logic w, input logic [7:0] a, d);
    logic ta, tw, tv;
    {s_axi_awaddr, s_axi_araddr} <= {24'h0, a, 24'h0, a};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    repeat (40) begin
      @(negedge clk);
      ta = w ? s_axi_awready : s_axi_arready;
      {tw, tv} = {s_axi_wready, w ? s_axi_bvalid : s_axi_rvalid};
      {got, resp} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tv) begin
        {s_axi_bready, s_axi_rready} <= 2'h0;
        @(posedge clk);
        return;
      end
    end
    errorCnt++;
    endSim;
  endtask : acc
  task automatic rd(input logic [7:0] a, e);
    acc(1'b0, a, 8'h0);
    chk(got, {24'h0, e});
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic frm(input logic [7:0] a);
    {k1, rxFrameStb} <= {a, 1'b1};
    wt(1);
    rxFrameStb <= 1'b0;
    wt(4);
  endtask : frm
  // ===============================================================
  // sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h0c, 8'h05);
    rd(8'h14, 8'h00);
    chk(resp, RESP_SLVERR);
    acc(1'b1, 8'h04, 8'h7f);
    for (i = 0; i < 5; i++) begin
      ev <= (i < 4) ? 4'h1 << i : 4'hf;
      wt(1);
      ev <= 4'h0;
      wt(3);
      chk(irq, i < 4);
      rd(8'h08, (i < 4) ? 8'h01 << i : 8'h0f);
      ack <= 4'hf;
      wt(1);
      ack <= 4'h0;
      acc(1'b1, 8'h04, (i < 3) ? 8'h7f : 8'h70);
      chk(irq, 1'b0);
    end
    $display("events done");
    z1 <= 8'h5a;
    frm(8'h11);
    chk({irq, rxZ1}, 9'h15a);
    rd(8'h08, 8'h40);
    frm(8'h11);
    chk(rxK1, 8'h00);
    frm(8'h11);
    chk(rxK1, 8'h11);
    rd(8'h08, 8'h10);
    for (i = 0; i < 11; i++) frm(i[0] ? 8'h11 : 8'h00);
    rd(8'h08, 8'h00);
    frm(8'h11);
    rd(8'h08, 8'ha0);
    repeat (2) frm(8'h11);
    rd(8'h08, 8'h20);
    $display("frames done");
    for (i = 0; i < 4; i++) begin
      act[i] <= 1'b1;
      wt(2);
      rd(8'h0c, 8'h05 | (8'h08 << i));
    end
    acc(1'b1, 8'h0c, 8'h00);
    chk(snapCnt, 1);
    acc(1'b1, 8'h0c, 8'h80);
    rd(8'h04, 8'h00);
    acc(1'b1, 8'h0c, 8'h00);
    chk(coreReset, 1'b0);
    acc(1'b1, 8'h04, 8'h80);
    alm <= 3'h5;
    wt(2);
    chk(rxRingData, 3'h5);
    acc(1'b1, 8'h04, 8'h00);
    lane <= 8'hff;
    txPos <= POS_K2;
    wt(2);
    chk(txByteOut, 8'hfe);
    txPos <= POS_E2;
    wt(2);
    chk(txByteOut, 8'h3c);
    txPos <= POS_DCC_UNUSED;
    wt(2);
    chk(txByteOut, 8'h00);
    acc(1'b1, 8'h10, 8'h44);
    rd(8'h10, 8'h44);
    chk(txByteOut, 8'hff);
    $display("control done");
    endSim;
  end
endmodule : tb
